// >>> rtl/scd_cfg.svh
// Purpose: offsets, field positions, reset values for the clock divider / gating select block
// Assumes: 32-bit register port with byte addresses
// Notes:   definitions only
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SCD_RUN_CFG_OFS     8'h60
`define SCD_COMP_CFG_OFS    8'h70
`define SCD_STATUS_OFS      8'h74

// ----------------------------------------
// run_clock_config_reg fields
// ----------------------------------------
`define SCD_RSVD_HI         31
`define SCD_RSVD_LO         28
`define SCD_ACG_BIT         27
`define SCD_DIV_HI          26
`define SCD_DIV_LO          23
`define SCD_USEDIV_BIT      22
`define SCD_SKIP_BIT        11

// ----------------------------------------
// companion_clock_config_reg fields
// ----------------------------------------
`define SCD_OVR_BIT         31
`define SCD_ALT_HI          26
`define SCD_ALT_LO          23

// ----------------------------------------
// reset values
// ----------------------------------------
`define SCD_ACG_RST         1'h0
`define SCD_DIV_RST         4'hF
`define SCD_USEDIV_RST      1'h0
`define SCD_SKIP_RST        1'h1
`define SCD_OVR_RST         1'h0
`define SCD_ALT_RST         4'hF
`define SCD_RSVD_VAL        4'h0

`endif

// >>> rtl/scd_pkg.sv
// Purpose: types for the clock divider / gating select block
// Assumes: nothing
// Notes:   one-hot power mode codes
package scd_pkg;

    typedef enum logic [2:0] {
        SCD_RUN   = 3'b001,
        SCD_SLEEP = 3'b010,
        SCD_DEEP  = 3'b100
    } scd_mode_t;

    typedef logic [3:0] scd_div_t;

endpackage

// >>> rtl/scd_clock_ctrl.sv
// Purpose: run-mode clock config upper fields: gating set select and system divider
// Assumes: single 20 MHz clk, synchronous active-high rst, inputs synchronous to clk
// Notes:   divided system clock is a one-cycle enable pulse, sysClkEn
`timescale 1ns/1ps
`include "scd_cfg.svh"

module scd_clock_ctrl
    import scd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    input  wire logic        sleepReq,
    input  wire logic        deepSleepReq,
    input  wire logic [3:0]  minDivisorLimit,
    input  wire logic [31:0] runGating,
    input  wire logic [31:0] sleepGating,
    input  wire logic [31:0] deepSleepGating,
    output logic      [31:0] periphClkEn,
    output logic             sysClkEn,
    output logic             sysSrcOsc,
    output logic             divActive,
    output logic      [3:0]  curDivisor
);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic      autoGate_r;
    scd_div_t  system_divisor_field_r;
    logic      useDiv_r;
    logic      pllSkip_r;
    logic      ovr_r;
    scd_div_t  altDiv_r;
    scd_mode_t mode_r;
    scd_mode_t mode_nxt;
    logic [31:0] gate_r;
    logic [31:0] gate_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    scd_div_t  cnt_r;
    scd_div_t  cnt_nxt;
    scd_div_t  curDiv_r;
    logic      divAct_r;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire selRun  = (regAddr == `SCD_RUN_CFG_OFS);
    wire selComp = (regAddr == `SCD_COMP_CFG_OFS);
    wire selStat = (regAddr == `SCD_STATUS_OFS);
    wire wrRun   = regWr && selRun;
    wire wrComp  = regWr && selComp;

    wire [31:0] runWord  = {`SCD_RSVD_VAL, autoGate_r, system_divisor_field_r, useDiv_r, 10'h000,
                            pllSkip_r, 11'h000};
    wire [31:0] compWord = {ovr_r, 4'h0, altDiv_r, 23'h000000};
    wire [31:0] statWord = {21'h000000, mode_r, divAct_r, pllSkip_r, 2'h0, curDiv_r};

    always_comb begin
        if (!regRd) begin
            rdata_nxt = 32'h00000000;
        end else if (selRun) begin
            rdata_nxt = runWord;
        end else if (selComp) begin
            rdata_nxt = compWord;
        end else if (selStat) begin
            rdata_nxt = statWord;
        end else begin
            rdata_nxt = 32'h00000000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            autoGate_r <= `SCD_ACG_RST;
            system_divisor_field_r   <= `SCD_DIV_RST;
            useDiv_r   <= `SCD_USEDIV_RST;
            pllSkip_r  <= `SCD_SKIP_RST;
        end else if (wrRun) begin
            autoGate_r <= regWdata[`SCD_ACG_BIT];
            system_divisor_field_r   <= regWdata[`SCD_DIV_HI:`SCD_DIV_LO];
            useDiv_r   <= regWdata[`SCD_USEDIV_BIT];
            pllSkip_r  <= regWdata[`SCD_SKIP_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_r    <= `SCD_OVR_RST;
            altDiv_r <= `SCD_ALT_RST;
        end else if (wrComp) begin
            ovr_r    <= regWdata[`SCD_OVR_BIT];
            altDiv_r <= regWdata[`SCD_ALT_HI:`SCD_ALT_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // gating set selection
    // ----------------------------------------
    // deep sleep takes priority if both requests are high
    assign mode_nxt = deepSleepReq ? SCD_DEEP : (sleepReq ? SCD_SLEEP : SCD_RUN);

    always_comb begin
        case (mode_r)
            SCD_SLEEP: gate_nxt = autoGate_r ? sleepGating : runGating;
            SCD_DEEP:  gate_nxt = autoGate_r ? deepSleepGating : runGating;
            default:   gate_nxt = runGating;
        endcase
    end

    // enables are registered so a mode or select change only lands on a clk edge
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r <= SCD_RUN;
            gate_r <= 32'h00000000;
        end else begin
            mode_r <= mode_nxt;
            gate_r <= gate_nxt;
        end
    end

    // ----------------------------------------
    // system divider
    // ----------------------------------------
    function automatic scd_div_t effDivisor(input logic ovr, input scd_div_t alt,
                                            input scd_div_t div, input logic skip,
                                            input scd_div_t minLim);
        scd_div_t d;
        d = ovr ? alt : div;
        if (!skip && (d < minLim)) begin
            d = minLim;
        end
        return d;
    endfunction

    wire       terminal  = (cnt_r == 4'h0);
    wire       newActive = useDiv_r || !pllSkip_r;
    wire [3:0] newDiv    = effDivisor(ovr_r, altDiv_r, system_divisor_field_r, pllSkip_r, minDivisorLimit);

    // divide by value+1; new settings load only at the end of a period, so no runt pulse
    assign cnt_nxt = terminal ? (newActive ? newDiv : 4'h0) : (cnt_r - 4'h1);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r    <= 4'h0;
            curDiv_r <= 4'h0;
            divAct_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            if (terminal) begin
                curDiv_r <= newActive ? newDiv : 4'h0;
                divAct_r <= newActive;
            end
        end
    end

    assign sysClkEn    = terminal;
    assign regRdata    = rdata_r;
    assign periphClkEn = gate_r;
    assign sysSrcOsc   = pllSkip_r;
    assign divActive   = divAct_r;
    assign curDivisor  = curDiv_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence runSeq;
        !sleepReq && !deepSleepReq ##1 1'b1;
    endsequence

    sequence pulseGap2;
        !sysClkEn ##1 sysClkEn;
    endsequence

    // enables seen at t+2 were loaded at t+1 from the run set sampled at t+1
    run_gating_a: assert property (@(posedge clk) disable iff (rst)
        runSeq |=> periphClkEn == $past(runGating))
        else $error("run mode enables not from run gating set");

    sleep_auto_a: assert property (@(posedge clk) disable iff (rst)
        (sleepReq && !deepSleepReq && autoGate_r) ##1 $stable(autoGate_r)
        |=> periphClkEn == $past(sleepGating))
        else $error("sleep enables not from sleep gating set");

    deep_auto_a: assert property (@(posedge clk) disable iff (rst)
        (deepSleepReq && autoGate_r) ##1 $stable(autoGate_r)
        |=> periphClkEn == $past(deepSleepGating))
        else $error("deep sleep enables not from deep gating set");

    sleep_noauto_a: assert property (@(posedge clk) disable iff (rst)
        ((sleepReq || deepSleepReq) && !autoGate_r) ##1 !autoGate_r
        |=> periphClkEn == $past(runGating))
        else $error("sleep without auto gating left run gating set");

    div_clamp_a: assert property (@(posedge clk) disable iff (rst)
        (terminal && !pllSkip_r && !ovr_r && system_divisor_field_r < minDivisorLimit)
        |=> curDivisor == $past(minDivisorLimit))
        else $error("pll divisor not clamped to minimum");

    div_noclamp_a: assert property (@(posedge clk) disable iff (rst)
        (terminal && pllSkip_r && useDiv_r && !ovr_r) |=> curDivisor == $past(system_divisor_field_r))
        else $error("oscillator divisor altered");

    alt_div_a: assert property (@(posedge clk) disable iff (rst)
        (terminal && pllSkip_r && useDiv_r && ovr_r) |=> curDivisor == $past(altDiv_r))
        else $error("alternate divisor not used");

    pll_force_a: assert property (@(posedge clk) disable iff (rst)
        (terminal && !pllSkip_r) |=> divActive)
        else $error("divider not forced with pll");

    use_div_a: assert property (@(posedge clk) disable iff (rst)
        (terminal && useDiv_r) |=> divActive && (sysClkEn == (curDivisor == 4'h0)))
        else $error("divider use enable ignored");

    rsvd_read_a: assert property (@(posedge clk) disable iff (rst)
        (regRd && selRun) |=> regRdata[`SCD_RSVD_HI:`SCD_RSVD_LO] == `SCD_RSVD_VAL)
        else $error("reserved bits not zero");

    skip_sel_a: assert property (@(posedge clk) disable iff (rst)
        wrRun |=> sysSrcOsc == $past(regWdata[`SCD_SKIP_BIT]))
        else $error("pll skip select not stored");

    // judged on the divisor loaded at the pulse, not the one that just ended
    no_runt_a: assert property (@(posedge clk) disable iff (rst)
        sysClkEn ##1 (curDivisor == 4'h1) |-> pulseGap2)
        else $error("short pulse on divided clock");

endmodule

// >>> tb/tb_scd_clock_ctrl.sv
// Purpose: self-checking bench for the clock divider / gating select block
// Assumes: 20 MHz clk, synchronous active-high rst held 6 cycles
// Notes:   divider periods are measured between sysClkEn pulses
`timescale 1ns/1ps
`include "scd_cfg.svh"

module tb_scd_clock_ctrl;

logic        clk;
logic        rst;
logic        regWr;
logic        regRd;
logic        sleepReq;
logic        deepSleepReq;
logic [7:0]  regAddr;
logic [3:0]  minDivisorLimit;
logic [31:0] regWdata;
logic [31:0] regRdata;
logic [31:0] runGating;
logic [31:0] sleepGating;
logic [31:0] deepSleepGating;
logic [31:0] periphClkEn;
logic        sysClkEn;
logic        sysSrcOsc;
logic        divActive;
logic [3:0]  curDivisor;
int          n_mismatch;
int          check_count;

scd_clock_ctrl scd_clock_ctrl_inst (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .sleepReq(sleepReq), .deepSleepReq(deepSleepReq),
    .minDivisorLimit(minDivisorLimit), .runGating(runGating), .sleepGating(sleepGating),
    .deepSleepGating(deepSleepGating), .periphClkEn(periphClkEn), .sysClkEn(sysClkEn),
    .sysSrcOsc(sysSrcOsc), .divActive(divActive), .curDivisor(curDivisor));

initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
end

// ----------------------------------------
// bus and compare helpers
// ----------------------------------------
task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
        n_mismatch++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
endtask

task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
        n_mismatch++;
        $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
endtask

task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
endtask

// read data stand only in the cycle after the strobe edge
task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
endtask

// bounded search: a stuck divider ends as a wrong period, not a hang
task automatic measure(output int per);
    int k;
    per = 0;
    for (k = 0; k < 40; k++) begin
        @(posedge clk);
        #1;
        if (sysClkEn === 1'b1) break;
    end
    do begin
        @(posedge clk);
        #1;
        per++;
    end while (sysClkEn !== 1'b1 && per < 40);
endtask

// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic reg_test;
    logic [31:0] d;
    rd_reg(`SCD_RUN_CFG_OFS, d);
    chk_word("run reset", 32'h0780_0800, d);
    rd_reg(`SCD_COMP_CFG_OFS, d);
    chk_word("companion reset", 32'h0780_0000, d);
    rd_reg(`SCD_STATUS_OFS, d);
    chk_word("status reset", 32'h0000_0140, d);
    @(posedge clk);
    #1;
    chk_word("read data cleared", 32'h0000_0000, regRdata);
    wr_reg(8'h00, 32'hFFFF_FFFF);
    rd_reg(8'h00, d);
    chk_word("unmapped", 32'h0000_0000, d);
    wr_reg(`SCD_RUN_CFG_OFS, 32'hFFFF_FFFF);
    rd_reg(`SCD_RUN_CFG_OFS, d);
    chk_word("run all ones", 32'h0FC0_0800, d);
    wr_reg(`SCD_RUN_CFG_OFS, 32'h0780_0800);
    $display("test registers done");
endtask

task automatic gate_case(input logic auto_gating_select, sl, dp, input logic [31:0] exp);
    wr_reg(`SCD_RUN_CFG_OFS, {4'h0, auto_gating_select, 4'hF, 1'b0, 10'h000, 1'b1, 11'h000});
    @(posedge clk);
    sleepReq <= sl;
    deepSleepReq <= dp;
    repeat (3) @(posedge clk);
    #1;
    chk_word("periphClkEn", exp, periphClkEn);
    $display("test gating done");
endtask

task automatic div_case(input logic useDiv, skip, ovr, input logic [3:0] dv, alt, lim);
    logic [3:0] eff;
    int         per;
    eff = ovr ? alt : dv;
    if (!skip && eff < lim) eff = lim;
    if (!useDiv && skip) eff = 4'h0;
    @(posedge clk);
    minDivisorLimit <= lim;
    wr_reg(`SCD_COMP_CFG_OFS, {ovr, 4'h0, alt, 23'h000000});
    wr_reg(`SCD_RUN_CFG_OFS, {5'h00, dv, useDiv, 10'h000, skip, 11'h000});
    measure(per);
    measure(per);
    chk_word("period", {28'h0000000, eff} + 32'h1, 32'(per));
    chk_word("curDivisor", {28'h0000000, eff}, {28'h0000000, curDivisor});
    chk_bit("divActive", useDiv | ~skip, divActive);
    chk_bit("sysSrcOsc", skip, sysSrcOsc);
    $display("test divider done");
endtask

task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask

initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    give_verdict();
end

initial begin
    n_mismatch = 0;
    check_count = 0;
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    sleepReq = 1'b0;
    deepSleepReq = 1'b0;
    minDivisorLimit = 4'h3;
    runGating = 32'h1111_1111;
    sleepGating = 32'h2222_2222;
    deepSleepGating = 32'h4444_4444;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    reg_test();
    gate_case(1'b0, 1'b0, 1'b0, 32'h1111_1111);
    gate_case(1'b0, 1'b1, 1'b0, 32'h1111_1111);
    gate_case(1'b0, 1'b0, 1'b1, 32'h1111_1111);
    gate_case(1'b1, 1'b1, 1'b0, 32'h2222_2222);
    gate_case(1'b1, 1'b0, 1'b1, 32'h4444_4444);
    gate_case(1'b1, 1'b1, 1'b1, 32'h4444_4444);
    gate_case(1'b1, 1'b0, 1'b0, 32'h1111_1111);
    div_case(1'b0, 1'b1, 1'b0, 4'h3, 4'h0, 4'h3);
    div_case(1'b1, 1'b1, 1'b0, 4'h3, 4'h0, 4'h3);
    div_case(1'b0, 1'b0, 1'b0, 4'h1, 4'h0, 4'h3);
    div_case(1'b0, 1'b0, 1'b0, 4'h4, 4'h0, 4'h3);
    div_case(1'b1, 1'b1, 1'b0, 4'h1, 4'h0, 4'h3);
    div_case(1'b1, 1'b1, 1'b1, 4'h1, 4'h5, 4'h3);
    div_case(1'b0, 1'b0, 1'b1, 4'h9, 4'h0, 4'h2);
    give_verdict();
end

endmodule
